/* File: rtl/gle_regs.vh */
`ifndef GLE_REGS_VH
`define GLE_REGS_VH
// ==================================================
// register offsets
`define GLE_OFF_ENABLE    4'h0
`define GLE_OFF_DIR       4'h1
`define GLE_OFF_VALUE     4'h2
`define GLE_OFF_RISE      4'h3
`define GLE_OFF_FALL      4'h4
`define GLE_OFF_HMASK     4'h5
`define GLE_OFF_LMASK     4'h6
`define GLE_OFF_CTRL      4'h7
`define GLE_OFF_IRQ_STAT  4'h8
`define GLE_OFF_IRQ_MASK  4'h9
// ==================================================
// control register fields
`define GLE_CTRL_PIN0_SEL 0
`define GLE_CTRL_EV0_SEL  1
`define GLE_CTRL_DV_SEL   2
`define GLE_CTRL_COMB_SEL 3
`define GLE_CTRL_INVERT   4
`define GLE_CTRL_WIDTH    5
`define GLE_CTRL_RESET    5'h00
// ==================================================
// irq status fields
`define GLE_IRQ_LOGIC     0
`define GLE_IRQ_EV0       1
`endif

/* File: rtl/gle_edge_detect.v */
`default_nettype none
// ==================================================
// synchronise pins and flag edges
module gle_edge_detect #(
  parameter N = 16
) (
  input  wire         clk,
  input  wire         reset,
  input  wire [N-1:0] pins_in,
  input  wire [N-1:0] watch,
  output wire [N-1:0] pins_sync,
  output wire [N-1:0] rise_pulse,
  output wire [N-1:0] fall_pulse
);
  reg [N-1:0] meta_reg;
  reg [N-1:0] sync_reg;
  reg [N-1:0] last_reg;
  reg [N-1:0] watch_reg;
  reg [2:0]   ready_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg  <= {N{1'b0}};
      sync_reg  <= {N{1'b0}};
      last_reg  <= {N{1'b0}};
      watch_reg <= {N{1'b0}};
      ready_reg <= 3'h0;
    end else begin
      meta_reg  <= pins_in;
      sync_reg  <= meta_reg;
      last_reg  <= sync_reg;
      watch_reg <= watch;
      ready_reg <= {ready_reg[1:0], 1'b1};
    end
  end

  assign pins_sync = sync_reg;
  // an edge counts only if the pin was watched before and after it
  // pipeline still holds reset zeros for three edges; a high pin would fake a rise
  assign rise_pulse = sync_reg & ~last_reg & watch & watch_reg
                    & {N{ready_reg[2]}}; // R12 R16
  assign fall_pulse = ~sync_reg & last_reg & watch & watch_reg
                    & {N{ready_reg[2]}}; // R12 R16
endmodule
`default_nettype wire

/* File: rtl/gle_logic_event.v */
// Notes on behaviour
// R01 - disabled or output pins never contribute
// R02 - source select one routes logic event
// R03 - invert bit flips the combined function
// R04 - delta/value select picks flags or pins
// R05 - delta: rise and high, fall and low
// R06 - value: pin and high, inverse and low
// R07 - combine select: any or all outputs
// R08 - mode pair decode; one-zero reserved
// R09 - delta or: any masked flag fires
// R10 - delta and: every masked flag set
// R11 - empty masks never fire in and-modes
// R12 - flags only from real transitions
// R13 - rise and fall flags kept apart
// R14 - logic event muxed onto event zero
// R15 - logic event available for pin zero
// R16 - rising and falling edges set flags
// R17 - value and: all levels match together
// R18 - pin zero output select drives event
// R19 - flags sticky until software clears
//
// Decided for this implementation: the plain strobed port and the address map.
`include "gle_regs.vh"
`default_nettype none
module gle_logic_event #(
  parameter N = 16
) (
  input  wire         clk,
  input  wire         reset,
  input  wire [3:0]   addr,
  input  wire [31:0]  wdata,
  input  wire         wr_stb,
  input  wire         rd_stb,
  output reg  [31:0]  rdata,
  input  wire [N-1:0] pins_in,
  output wire [N-1:0] pins_out,
  output wire [N-1:0] pins_oe,
  input  wire         passthru_event_zero,
  output wire         event_line_zero,
  output wire         logic_event_out,
  output wire         irq
);
  // ==================================================
  // registers
  reg [N-1:0]               pin_enable_bits_reg;
  reg [N-1:0]               pin_direction_bits_reg;
  reg [N-1:0]               out_value_reg;
  reg [N-1:0]               rise_flags_reg;
  reg [N-1:0]               fall_flags_reg;
  reg [N-1:0]               high_mask_reg;
  reg [N-1:0]               low_mask_reg;
  reg [`GLE_CTRL_WIDTH-1:0] global_control_reg;
  reg [1:0]                 irq_stat_reg;
  reg [1:0]                 irq_mask_reg;
  reg                       logic_prev_reg;
  reg                       ev0_prev_reg;

  wire [N-1:0] pins_sync;
  wire [N-1:0] rise_pulse;
  wire [N-1:0] fall_pulse;
  wire [N-1:0] input_ok;
  wire [N-1:0] pin_value_bits;
  wire [N-1:0] src_high;
  wire [N-1:0] src_low;
  wire [N-1:0] hm_eff;
  wire [N-1:0] lm_eff;
  wire [N-1:0] hit_high;
  wire [N-1:0] hit_low;
  wire         any_hit;
  wire         all_hit;
  wire         mask_empty;
  reg          func_true;
  wire         dv_sel;
  wire         comb_sel;

  function [31:0] widen;
    input [N-1:0] v;
    begin
      widen = {{(32-N){1'b0}}, v};
    end
  endfunction

  // ==================================================
  // edge capture
  assign input_ok = pin_enable_bits_reg & ~pin_direction_bits_reg; // R01

  gle_edge_detect #(.N(N)) u_edge (
    .clk        (clk),
    .reset      (reset),
    .pins_in    (pins_in),
    .watch      (input_ok),
    .pins_sync  (pins_sync),
    .rise_pulse (rise_pulse),
    .fall_pulse (fall_pulse)
  );

  // outputs read back their value register bit, not the pad
  assign pin_value_bits = (pins_sync & ~pin_direction_bits_reg)
                        | (out_value_reg & pin_direction_bits_reg);

  // ==================================================
  // mask logic
  assign dv_sel   = global_control_reg[`GLE_CTRL_DV_SEL];
  assign comb_sel = global_control_reg[`GLE_CTRL_COMB_SEL];
  assign src_high = dv_sel ? pins_sync : rise_flags_reg;  // R04
  assign src_low  = dv_sel ? ~pins_sync : fall_flags_reg; // R04
  // excluded pins drop out of the mask entirely
  assign hm_eff   = high_mask_reg & input_ok; // R01
  assign lm_eff   = low_mask_reg & input_ok;  // R01
  assign hit_high = src_high & hm_eff;        // R05 R06
  assign hit_low  = src_low & lm_eff;         // R05 R06 R13
  assign any_hit  = |(hit_high | hit_low);    // R09
  assign all_hit  = ((src_high & hm_eff) == hm_eff)
                 && ((src_low & lm_eff) == lm_eff); // R10 R17
  assign mask_empty = ~|(hm_eff | lm_eff);

  // reserved pair evaluates false, a safe idle level
  always @* begin
    case ({dv_sel, comb_sel}) // R07 R08
      2'b00:   func_true = any_hit;
      2'b01:   func_true = all_hit & ~mask_empty; // R11
      2'b11:   func_true = all_hit & ~mask_empty; // R11
      default: func_true = 1'b0;
    endcase
  end

  assign logic_event_out = func_true ^ global_control_reg[`GLE_CTRL_INVERT]; // R03
  assign event_line_zero = global_control_reg[`GLE_CTRL_EV0_SEL] ?
                           logic_event_out : passthru_event_zero; // R02 R14

  // ==================================================
  // pads
  assign pins_oe = pin_enable_bits_reg & pin_direction_bits_reg;
  assign pins_out[N-1:1] = out_value_reg[N-1:1];
  assign pins_out[0] = global_control_reg[`GLE_CTRL_PIN0_SEL] ?
                       logic_event_out : out_value_reg[0]; // R15 R18

  // ==================================================
  // register writes, sticky flags
  wire wr_rise = wr_stb && (addr == `GLE_OFF_RISE);
  wire wr_fall = wr_stb && (addr == `GLE_OFF_FALL);
  wire rd_stat = rd_stb && (addr == `GLE_OFF_IRQ_STAT);
  wire logic_rise = logic_event_out & ~logic_prev_reg;
  wire ev0_rise = event_line_zero & ~ev0_prev_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_enable_bits_reg    <= {N{1'b0}};
      pin_direction_bits_reg <= {N{1'b0}};
      out_value_reg          <= {N{1'b0}};
      rise_flags_reg         <= {N{1'b0}};
      fall_flags_reg         <= {N{1'b0}};
      high_mask_reg          <= {N{1'b0}};
      low_mask_reg           <= {N{1'b0}};
      global_control_reg     <= `GLE_CTRL_RESET;
      irq_stat_reg           <= 2'h0;
      irq_mask_reg           <= 2'h0;
      logic_prev_reg         <= 1'b0;
      ev0_prev_reg           <= 1'b0;
    end else begin
      logic_prev_reg <= logic_event_out;
      ev0_prev_reg   <= event_line_zero;
      if (wr_stb) begin
        case (addr)
          `GLE_OFF_ENABLE:   pin_enable_bits_reg    <= wdata[N-1:0];
          `GLE_OFF_DIR:      pin_direction_bits_reg <= wdata[N-1:0];
          `GLE_OFF_VALUE:    out_value_reg          <= wdata[N-1:0];
          `GLE_OFF_HMASK:    high_mask_reg          <= wdata[N-1:0];
          `GLE_OFF_LMASK:    low_mask_reg           <= wdata[N-1:0];
          `GLE_OFF_CTRL:     global_control_reg     <= wdata[`GLE_CTRL_WIDTH-1:0];
          `GLE_OFF_IRQ_MASK: irq_mask_reg           <= wdata[1:0];
          default: ;
        endcase
      end
      // write one clears; a new edge in the same cycle wins
      rise_flags_reg <= (rise_flags_reg & ~(wr_rise ? wdata[N-1:0] : {N{1'b0}}))
                      | rise_pulse; // R16 R19 R13
      fall_flags_reg <= (fall_flags_reg & ~(wr_fall ? wdata[N-1:0] : {N{1'b0}}))
                      | fall_pulse; // R16 R19 R13
      irq_stat_reg <= (rd_stat ? 2'h0 : irq_stat_reg) | {ev0_rise, logic_rise};
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ==================================================
  // read port, data in the cycle after the strobe
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h0;
    end else if (rd_stb) begin
      case (addr)
        `GLE_OFF_ENABLE:   rdata <= widen(pin_enable_bits_reg);
        `GLE_OFF_DIR:      rdata <= widen(pin_direction_bits_reg);
        `GLE_OFF_VALUE:    rdata <= widen(pin_value_bits);
        `GLE_OFF_RISE:     rdata <= widen(rise_flags_reg);
        `GLE_OFF_FALL:     rdata <= widen(fall_flags_reg);
        `GLE_OFF_HMASK:    rdata <= widen(high_mask_reg);
        `GLE_OFF_LMASK:    rdata <= widen(low_mask_reg);
        `GLE_OFF_CTRL:     rdata <= {27'h0, global_control_reg};
        `GLE_OFF_IRQ_STAT: rdata <= {30'h0, irq_stat_reg};
        `GLE_OFF_IRQ_MASK: rdata <= {30'h0, irq_mask_reg};
        default:           rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/gle_logic_event_props.sv */
`default_nettype none
// ==========
// port checker
module gle_logic_event_props #(
  parameter N = 16
) (
  input wire logic         clk,
  input wire logic         reset,
  input wire logic [3:0]   addr,
  input wire logic [31:0]  wdata,
  input wire logic         wr_stb,
  input wire logic [N-1:0] pins_in,
  input wire logic [N-1:0] pins_out,
  input wire logic [N-1:0] pins_oe,
  input wire logic         passthru_event_zero,
  input wire logic         event_line_zero,
  input wire logic         logic_event_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [N-1:0] en_q, dir_q, val_q, hm_q, lm_q, s1, s2, s3;
  logic [4:0]   ctrl_q;
  wire  [N-1:0] eff = en_q & ~dir_q;
  wire  [N-1:0] h = hm_q & eff;
  wire  [N-1:0] l = lm_q & eff;
  wire          vand = (|(h | l)) && ((s2 & h) == h) && ((~s2 & l) == l);
  wire          chg = |(s2 ^ s3);
  // mirrors only writes; reads never change setup
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {en_q, dir_q, val_q, hm_q, lm_q, s1, s2, s3} <= '0;
      ctrl_q <= 5'h00;
    end else begin
      {s3, s2, s1} <= {s2, s1, pins_in};
      if (wr_stb) begin
        case (addr)
          4'h0: en_q <= wdata[N-1:0];
          4'h1: dir_q <= wdata[N-1:0];
          4'h2: val_q <= wdata[N-1:0];
          4'h5: hm_q <= wdata[N-1:0];
          4'h6: lm_q <= wdata[N-1:0];
          4'h7: ctrl_q <= wdata[4:0];
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_ev0_mux: assert property (event_line_zero == (ctrl_q[1] ? logic_event_out
    : passthru_event_zero)) else $error("event line zero source wrong");
  a_pin0_event: assert property (pins_oe[0] && ctrl_q[0] |-> pins_out[0] == logic_event_out)
    else $error("pin zero not driving logic event");
  a_pin0_gpio: assert property (pins_oe[0] && !ctrl_q[0] |-> pins_out[0] == val_q[0])
    else $error("pin zero not driving value bit");
  a_empty_and: assert property (ctrl_q[3] && h == '0 && l == '0
    |-> logic_event_out == ctrl_q[4]) else $error("empty and mask fired");
  a_reserved_mode: assert property (ctrl_q[3:2] == 2'b01 |-> logic_event_out == ctrl_q[4])
    else $error("reserved mode fired");
  a_value_and: assert property (ctrl_q[3:2] == 2'b11
    |-> logic_event_out == (vand ^ ctrl_q[4])) else $error("value and result wrong");
  a_no_false_edge: assert property ($rose(logic_event_out) && !ctrl_q[2] && !ctrl_q[4]
    |-> $past(chg) || $past(wr_stb)) else $error("delta event without pin change");
  a_flag_sticky: assert property (logic_event_out && !ctrl_q[2] && !ctrl_q[4] && !wr_stb
    |=> logic_event_out) else $error("delta event dropped");
  cover property (ctrl_q[3:2] == 2'b00 && $rose(logic_event_out));
  cover property (ctrl_q[3:2] == 2'b10 && $rose(logic_event_out));
  cover property (ctrl_q[1] && $rose(event_line_zero));
endmodule
bind gle_logic_event gle_logic_event_props #(.N(N)) gle_logic_event_props_i (.clk(clk),
  .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .pins_in(pins_in),
  .pins_out(pins_out), .pins_oe(pins_oe), .passthru_event_zero(passthru_event_zero),
  .event_line_zero(event_line_zero), .logic_event_out(logic_event_out));
`default_nettype wire

/* File: tb/gle_irq_sink.sv */
`default_nettype none
// ==========
// cpu and dma side: counts event line zero rises
module gle_irq_sink (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       event_line_zero,
  output var  logic [7:0] ev_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_reg;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      last_reg <= 1'b0;
      ev_count <= 8'h00;
    end else begin
      last_reg <= event_line_zero;
      if (event_line_zero && !last_reg) ev_count <= ev_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: tb/gle_logic_event_tb.sv */
`default_nettype none
// ==========
// bench
module gle_logic_event_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, wr_stb, rd_stb, pt, e, elz, leo, irq;
  logic [3:0]  addr;
  logic [4:0]  c;
  logic [7:0]  evc;
  logic [31:0] wdata, rdata, d, r;
  logic [15:0] pv, pins_out, pins_oe, hm, lm, pm;
  wire  [15:0] pins_in = (pins_oe & pins_out) | (~pins_oe & pv);
  int          errors, samples_checked;
  gle_logic_event #(.N(16)) gle_logic_event_i (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pins_in(pins_in),
    .pins_out(pins_out), .pins_oe(pins_oe), .passthru_event_zero(pt),
    .event_line_zero(elz), .logic_event_out(leo), .irq(irq));
  gle_irq_sink gle_irq_sink_i (.clk(clk), .reset(reset), .event_line_zero(elz), .ev_count(evc));
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // pin zero and pin fifteen are never enabled inputs
  function automatic logic ev(input logic [15:0] p, a, b, input logic i);
    a = a & 16'h7ffe;
    b = b & 16'h7ffe;
    return i ^ ((|(a | b)) && ((p & a) == a) && ((~p & b) == b));
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, s, x);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(negedge clk);
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // sync takes two edges, flag a third
  task pw(input logic [15:0] v, input logic p);
    @(posedge clk);
    pv <= v;
    pt <= p;
    repeat (4) @(negedge clk);
  endtask
  task stop_test;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    stop_test;
  end
  initial begin
    {wr_stb, rd_stb, addr, wdata, pv, pt, errors, samples_checked} = '0;
    reset = 1'b1;
    r = 32'h59900911;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    wr(4'h0, 32'h7fff);
    wr(4'h1, 32'h8001);
    wr(4'h2, 32'h1);
    chk(pins_oe, 32'h1);
    chk(pins_out, 32'h1);
    wr(4'h3, 32'hffff);
    wr(4'h5, 32'h2);
    wr(4'h7, 32'h2);
    pw(16'h2, 1'b0);
    chk(elz, 1);
    chk(irq, 0);
    wr(4'h9, 32'h1);
    chk(irq, 1);
    rd(4'h8);
    chk(d[0], 1);
    chk(irq, 0);
    rd(4'h3);
    chk(d, 32'h2);
    rd(4'h4);
    chk(d, 32'h0);
    wr(4'h3, 32'hffff);
    chk(leo, 0);
    pw(16'h0, 1'b0);
    chk(leo, 0);
    pw(16'h2, 1'b0);
    chk(leo, 1);
    $display("delta or done");
    wr(4'h3, 32'hffff);
    wr(4'h7, 32'h0a);
    wr(4'h5, 32'h6);
    wr(4'h6, 32'h2);
    pw(16'h0, 1'b0);
    chk(leo, 0);
    pw(16'h6, 1'b0);
    chk(leo, 1);
    wr(4'h5, 32'h0);
    wr(4'h6, 32'h0);
    chk(leo, 0);
    // pins 1 and 2 are high, so a value decode would fire here
    wr(4'h5, 32'h6);
    wr(4'h7, 32'h04);
    chk(leo, 0);
    wr(4'h7, 32'h14);
    chk(leo, 1);
    $display("delta and done");
    repeat (24) begin
      r = lf(r);
      hm = r[15:0] & 16'h80f1;
      lm = r[31:16] & 16'h0f0e;
      c = {r[31], 2'b11, r[30], 1'b1};
      wr(4'h5, {16'h0, hm});
      wr(4'h6, {16'h0, lm});
      wr(4'h7, {27'h0, c});
      r = lf(r);
      // half the draws match the masks so the and can fire
      pm = r[0] ? ((r[15:0] | hm) & ~lm) : r[15:0];
      pw(pm, r[17]);
      e = ev(pm, hm, lm, c[4]);
      chk(leo, e);
      chk(pins_out[0], e);
      chk(elz, c[1] ? e : r[17]);
    end
    $display("value and done");
    chk(evc != 8'h00, 1);
    stop_test;
  end
endmodule
`default_nettype wire
